//--- logic/seq_slot_pkg.sv
// Overview of operation
// - Wait flag set: slot value is idle time
// - Idle time equals value times ten milliseconds
// - Wait flag clear: value is waveform identifier
// - Trigger bit starts playback at first slot
// - After waveform ends, advance to next slot
// - Stop at zero identifier or eighth slot
// - Zero identifier stops, plays nothing
// - Slot bit seven flag, six-zero value, reset zero
package seq_slot_pkg;

  // Register map, byte addresses on the register port
  localparam logic [7:0] TRIGGER_ADDR    = 8'h0c;  // Playback trigger register
  localparam logic [7:0] FIRST_SLOT_ADDR = 8'h0f;  // First sequence slot
  localparam logic [7:0] LAST_SLOT_ADDR  = 8'h16;  // Eighth sequence slot
  localparam logic [7:0] SLOT_FOUR_ADDR  = 8'h12;  // sequence_slot_four
  localparam logic [7:0] SLOT_FIVE_ADDR  = 8'h13;  // sequence_slot_five
  localparam logic [7:0] STATUS_ADDR     = 8'h30;  // Sequencer status, read only

  // Field layout
  localparam int          TRIGGER_BIT     = 0;      // Start bit in trigger register
  localparam int          WAIT_FLAG_BIT   = 7;      // Wait flag position in a slot
  localparam int          SLOT_COUNT      = 8;      // Slots walked per playback
  localparam logic [7:0]  SLOT_RESET      = 8'h00;  // Slot reset value
  localparam logic [6:0]  STOP_ID         = 7'h00;  // Stop marker identifier

  // Timing: wait unit and its cycle count at 25 MHz
  localparam int WAIT_UNIT_NS  = 10_000_000;              // 10 ms
  localparam int CLK_PERIOD_NS = 40;                      // 25 MHz clock
  localparam int WAIT_UNIT_CYC = WAIT_UNIT_NS / CLK_PERIOD_NS;  // 250000 cycles

  // One slot as stored
  typedef struct packed {
    logic       wait_flag;  // Value is a wait count when set
    logic [6:0] value;      // Identifier or wait count
  } slot_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;   // Byte address
    logic [7:0] wdata;  // Write data
    logic       wr;     // Write strobe
    logic       rd;     // Read strobe
  } reg_req_t;

  // Request to the waveform player outside
  typedef struct packed {
    logic       start;  // One-cycle start pulse
    logic [6:0] id;     // Library waveform identifier
  } play_req_t;

  // Slot index decode: slot number for an address, valid flag on top
  function automatic logic [3:0] slot_of(input logic [7:0] addr);
    logic [7:0] off;
    off = addr - FIRST_SLOT_ADDR;
    if (addr >= FIRST_SLOT_ADDR && addr <= LAST_SLOT_ADDR) begin
      slot_of = {1'b1, off[2:0]};
    end else begin
      slot_of = 4'h0;
    end
  endfunction

endpackage

//--- logic/wait_timer.sv
`timescale 1ns/1ps
// Counts count times unit_cycles, then pulses done
module wait_timer
  import seq_slot_pkg::*;
#(
  parameter int UNIT_CYCLES = WAIT_UNIT_CYC  // Cycles in one wait unit
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic [6:0] count,
  output logic            done
);

  // Elaboration check: a unit of no cycles cannot be counted down
  if (UNIT_CYCLES < 1) begin : g_bad_unit
    $error("UNIT_CYCLES must be at least one");
  end

  localparam int UW = $clog2(UNIT_CYCLES + 1);

  logic [UW-1:0] unit_ff;   // Cycles left in the current unit
  logic [6:0]    units_ff;  // Units left
  logic          run_ff;    // Timer running

  // Unit and unit-count down counters; zero count ends at once
  always_ff @(posedge clk) begin
    if (reset) begin
      unit_ff  <= '0;
      units_ff <= 7'h00;
      run_ff   <= 1'b0;
      done     <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        units_ff <= count;
        unit_ff  <= UW'(UNIT_CYCLES - 1);
        run_ff   <= (count != 7'h00);
        done     <= (count == 7'h00);
      end else if (run_ff) begin
        if (unit_ff != '0) begin
          unit_ff <= unit_ff - UW'(1);
        end else if (units_ff == 7'h01) begin
          run_ff <= 1'b0;
          done   <= 1'b1;
        end else begin
          units_ff <= units_ff - 7'h01;
          unit_ff  <= UW'(UNIT_CYCLES - 1);
        end
      end
    end
  end

endmodule // wait_timer

//--- logic/slot_regs.sv
`timescale 1ns/1ps
// Holds the two sequence slots reached over the register port
module slot_regs
  import seq_slot_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     reset,
  input  wire logic     ce,
  input  wire reg_req_t req,
  output slot_t         slot_four,
  output slot_t         slot_five
);

  // Slot writes; both fields writable, reset to zero
  always_ff @(posedge clk) begin
    if (reset) begin
      slot_four <= slot_t'(SLOT_RESET);
      slot_five <= slot_t'(SLOT_RESET);
    end else if (ce && req.wr) begin
      if (req.addr == SLOT_FOUR_ADDR) begin
        slot_four <= slot_t'(req.wdata);
      end
      if (req.addr == SLOT_FIVE_ADDR) begin
        slot_five <= slot_t'(req.wdata);
      end
    end
  end

endmodule // slot_regs

//--- logic/waveform_sequence_slots.sv
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
// Sequencer for the two held slots; other slots arrive on a port
module waveform_sequence_slots
  import seq_slot_pkg::*;
#(
  parameter int UNIT_CYCLES = WAIT_UNIT_CYC  // Cycles per 10 ms wait unit
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Sequencer side: slots from outside and the waveform player
  input  wire logic [7:0] other_slot,   // Slot at slot_index, from the rest of the device
  output logic      [2:0] slot_index,   // Slot now being used
  output logic      [6:0] play_id,      // Waveform to play
  output logic            play_start,   // One-cycle start to waveform player
  input  wire logic       play_done,    // Waveform finished pulse
  output logic            busy          // Playback in progress
);

  typedef enum {IDLE, FETCH, PLAY, WAITING} state_t;

  reg_req_t  req;         // Bundled register request
  slot_t     slot_four;   // Slot four contents
  slot_t     slot_five;   // Slot five contents
  slot_t     cur;         // Slot at the current index
  state_t    state_ff;    // Sequencer state
  logic      go;          // Trigger write seen this cycle
  logic      wt_start;    // Start the wait timer
  logic      wt_done;     // Wait elapsed
  logic      last;        // Current slot is the eighth
  logic [3:0] hit;        // Decoded slot of the access
  logic      launch;      // Trigger accepted while idle
  logic      play_go;     // Identifier slot fetched: start the player
  logic      slot_end;    // Current slot is over, played or waited
  logic      advance;     // Step on to the next slot
  logic      finish;      // Playback ends at this edge

  assign req  = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign go   = wr && (addr == TRIGGER_ADDR) && wdata[TRIGGER_BIT];
  assign last = (slot_index == 3'(SLOT_COUNT - 1));
  assign hit  = slot_of(addr);

  // Elaboration checks: the 3-bit index and the held slots depend on the map
  if (UNIT_CYCLES < 1) begin : g_bad_unit
    $error("UNIT_CYCLES must be at least one");
  end
  if (SLOT_COUNT != 8) begin : g_bad_count
    $error("slot index is three bits wide and walks eight slots");
  end
  if (LAST_SLOT_ADDR - FIRST_SLOT_ADDR != 8'(SLOT_COUNT - 1)) begin : g_bad_map
    $error("slot address range does not match the slot count");
  end
  if (SLOT_FOUR_ADDR < FIRST_SLOT_ADDR || SLOT_FIVE_ADDR > LAST_SLOT_ADDR) begin : g_bad_held
    $error("held slots lie outside the slot range");
  end

  slot_regs u_regs (
    .clk       (clk),
    .reset     (reset),
    .ce        (ce),
    .req       (req),
    .slot_four (slot_four),
    .slot_five (slot_five)
  );

  wait_timer #(.UNIT_CYCLES(UNIT_CYCLES)) u_wait (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .start (wt_start),
    .count (cur.value),
    .done  (wt_done)
  );

  // Pick the slot under the index: own registers or the port
  always_comb begin
    case (slot_index)
      3'(SLOT_FOUR_ADDR - FIRST_SLOT_ADDR): cur = slot_four;
      3'(SLOT_FIVE_ADDR - FIRST_SLOT_ADDR): cur = slot_five;
      default:                              cur = slot_t'(other_slot);
    endcase
  end

  // How a run unfolds, one clock at a time, every step with ce high:
  //  - A trigger write is heard only while idle; the next cycle shows busy
  //    high and the index at the first slot.
  //  - Fetch looks at the slot under the index for one cycle. Indices three
  //    and four come from the held registers, every other index from the
  //    other_slot port, which must already show that slot in the fetch cycle.
  //  - A wait slot starts the timer and parks the walk in the waiting state.
  //    The timer ends value times UNIT_CYCLES cycles after the fetch edge and
  //    the walk leaves one cycle later; a zero value waits about one cycle.
  //  - An identifier slot pulses play_start for one cycle with play_id beside
  //    it; play_id then holds until the next identifier slot is fetched.
  //  - An identifier of zero ends the run at once and nothing is played.
  //  - play_done is heard only while a waveform plays; a stray pulse at any
  //    other time is ignored, so the player cannot cut a wait short.
  //  - After a played or waited slot the index steps by one and the next
  //    slot is fetched; after the eighth slot busy falls instead.
  //  - The wait flag is tested before the stop marker, so a wait slot of
  //    value zero still counts as a slot and the walk goes on after it.
  //  - The trigger register itself lives elsewhere; only the write is seen,
  //    and a second trigger during a run is dropped rather than queued.
  //  - A long wait holds the index still for its whole length; software can
  //    follow the walk only through the status word.

  // Wait timer starts when a wait slot is fetched
  assign wt_start = (state_ff == FETCH) && cur.wait_flag;

  // A slot is over when its waveform ends or its wait elapses
  assign slot_end = ((state_ff == PLAY) && play_done)
                 || ((state_ff == WAITING) && wt_done);

  // Decisions of the walk for this cycle, shared by the state, index, player and busy flops below
  always_comb begin
    launch  = 1'b0;
    play_go = 1'b0;
    advance = 1'b0;
    finish  = 1'b0;
    case (state_ff)
      // Only an idle sequencer hears the trigger; a busy one ignores it
      IDLE: begin
        launch = go;
      end
      // Flag first, so a wait slot of value zero still waits
      FETCH: begin
        if (cur.wait_flag) begin
          // The timer takes over; nothing is played for this slot
          play_go = 1'b0;
        end else if (cur.value == STOP_ID) begin
          finish = 1'b1;
        end else begin
          play_go = 1'b1;
        end
      end
      // Played and waited slots advance alike; the eighth ends the run
      PLAY, WAITING: begin
        if (slot_end && last) begin
          finish = 1'b1;
        end else if (slot_end) begin
          advance = 1'b1;
        end
      end
      // A lost state code falls back to idle
      default: begin
        finish = 1'b1;
      end
    endcase
  end

  // Sequencer state; the walk is fetch, then play or wait, then fetch again
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= IDLE;
    end else if (ce) begin
      // Ending wins over every other move
      if (finish) begin
        state_ff <= IDLE;
      end else if (launch || advance) begin
        state_ff <= FETCH;
      end else if (wt_start) begin
        state_ff <= WAITING;
      end else if (play_go) begin
        state_ff <= PLAY;
      end
    end
  end

  // Slot index: first slot on a trigger, then one step per finished slot
  always_ff @(posedge clk) begin
    if (reset) begin
      slot_index <= 3'h0;
    end else if (ce) begin
      // A run always starts over at the first slot
      if (launch) begin
        slot_index <= 3'h0;
      end else if (advance) begin
        slot_index <= slot_index + 3'h1;
      end
    end
  end

  // Player request: identifier held, start pulsed for one cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      play_id    <= 7'h00;
      play_start <= 1'b0;
    end else if (ce) begin
      play_start <= play_go;
      // Identifier only moves with a new start, so the player may read it late
      if (play_go) begin
        play_id <= cur.value;
      end
    end
  end

  // Busy from the accepted trigger to the end of the walk
  always_ff @(posedge clk) begin
    if (reset) begin
      busy <= 1'b0;
    end else if (ce) begin
      // Rises with the trigger, falls at a stop marker or after slot eight
      if (launch) begin
        busy <= 1'b1;
      end else if (finish) begin
        busy <= 1'b0;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  // Status word: busy in bit three, slot index below it
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= 8'h00;
      if (rd) begin
        if (addr == SLOT_FOUR_ADDR) begin
          rdata <= slot_four;
        end else if (addr == SLOT_FIVE_ADDR) begin
          rdata <= slot_five;
        end else if (addr == STATUS_ADDR) begin
          rdata <= {4'h0, busy, slot_index};
        end else if (hit[3]) begin
          rdata <= 8'h00;  // Other slots live elsewhere
        end
      end
    end
  end

endmodule // waveform_sequence_slots

//--- bench/seq_slots_checker.sv
`timescale 1ns/1ps
// Port checks; the wait span assumes UNIT_CYCLES of 4
module seq_slots_checker
  import seq_slot_pkg::*;
#(
  parameter int UNIT_CYCLES = 4  // Cycles per wait unit
) (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] other_slot,
  input wire logic [2:0] slot_index,
  input wire logic [6:0] play_id,
  input wire logic       play_start,
  input wire logic       play_done,
  input wire logic       busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_rdata_quiet: assert property (ce && !rd |=> rdata == 8'h00)
    else $error("read data outside read slot");
  a_trig_start: assert property (ce && !busy && wr && addr == TRIGGER_ADDR && wdata[0]
    |=> busy && slot_index == 3'd0) else $error("trigger did not start slot 0");
  a_start_id: assert property (play_start |-> busy && play_id != STOP_ID)
    else $error("zero waveform started");
  a_id_source: assert property (play_start && slot_index != 3'd3 && slot_index != 3'd4
    |-> play_id == $past(other_slot[6:0]) && !$past(other_slot[7])) else $error("wrong id");
  a_slot_advance: assert property (busy && play_done && slot_index != 3'd7
    |=> busy && slot_index == $past(slot_index) + 3'd1) else $error("no advance");
  a_last_end: assert property (busy && play_done && slot_index == 3'd7 |=> !busy)
    else $error("run past eighth slot");
  a_wait_span: assert property (busy && $changed(slot_index) && slot_index == 3'd1
    && other_slot == 8'h82 |-> (slot_index == 3'd1 && !play_start)[*8] ##[1:4]
    slot_index == 3'd2) else $error("wait length wrong");
  a_zero_stop: assert property ($rose(busy) && other_slot == 8'h00
    |=> !busy && !play_start) else $error("zero slot did not stop");
  cover property (play_start);
  cover property ($fell(busy));
  cover property (busy && play_done && slot_index == 3'd7);
  cover property (busy && $changed(slot_index) && other_slot[WAIT_FLAG_BIT]);
endmodule // seq_slots_checker
bind waveform_sequence_slots seq_slots_checker #(.UNIT_CYCLES(UNIT_CYCLES)) chk_inst (
  .clk(clk), .reset(reset), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .other_slot(other_slot), .slot_index(slot_index), .play_id(play_id),
  .play_start(play_start), .play_done(play_done), .busy(busy));

//--- bench/tb_top.sv
`timescale 1ns/1ps
// Random slot sets played against a reference walk of all eight slots
module tb_top;
  import seq_slot_pkg::*;
  logic       clk, reset, ce, wr, rd, play_done, play_start, busy;
  logic [7:0] addr, wdata, rdata, other_slot;
  logic [2:0] slot_index, dly;
  logic [6:0] play_id;
  logic [7:0] slots [8];  // Reference image of all slots
  logic [6:0] got_q [$];  // Waveforms the player was asked for
  logic [6:0] exp_q [$];  // Waveforms the walk predicts
  int         seed = 32'h3f1d;
  int         n_mismatch = 0;
  int         check_count = 0;

  waveform_sequence_slots #(.UNIT_CYCLES(4)) waveform_sequence_slots_inst (
    .clk(clk), .reset(reset), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .other_slot(other_slot), .slot_index(slot_index), .play_id(play_id),
    .play_start(play_start), .play_done(play_done), .busy(busy));
  // Slots other than four and five come from the reference image
  assign other_slot = slots[slot_index];

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Player: finishes each waveform one to four cycles after its start
  always @(posedge clk) begin
    play_done <= 1'b0;
    if (reset) begin
      dly <= 3'd0;
    end else if (play_start === 1'b1) begin
      got_q.push_back(play_id);
      dly <= 3'd1 + 3'($unsigned($random(seed)) % 4);
    end else if (dly != 3'd0) begin
      dly <= dly - 3'd1;
      play_done <= (dly == 3'd1);
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Short waits keep runs brief; a zero value is a stop marker
  function automatic logic [7:0] rnd_slot();
    logic [7:0] r;
    r = 8'($random(seed));
    if (r[4:3] == 2'b00) return {6'b100000, r[1:0]};
    if (r[7:5] == 3'b000) return 8'h00;
    return {1'b0, r[6:0] | 7'h01};
  endfunction
  // Walk the slots: waits play nothing, a zero id ends the run
  function automatic void predict();
    exp_q = {};
    for (int i = 0; i < SLOT_COUNT; i++) begin
      if (slots[i][WAIT_FLAG_BIT]) continue;
      if (slots[i][6:0] == STOP_ID) break;
      exp_q.push_back(slots[i][6:0]);
    end
  endfunction

  initial begin
    {reset, ce, wr, rd, addr, wdata} = {2'b11, 2'b00, 16'h0000};
    foreach (slots[i]) slots[i] = 8'h00;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd_chk(SLOT_FOUR_ADDR, SLOT_RESET);
    rd_chk(SLOT_FIVE_ADDR, SLOT_RESET);
    rd_chk(8'h20, 8'h00);
    rd_chk(STATUS_ADDR, 8'h00);
    rd_chk(FIRST_SLOT_ADDR, 8'h00);
    // Clock enable low: a slot write must not land
    ce <= 1'b0;
    wr_reg(SLOT_FOUR_ADDR, 8'h55);
    ce <= 1'b1;
    rd_chk(SLOT_FOUR_ADDR, SLOT_RESET);
    for (int n = 0; n < 40; n++) begin
      foreach (slots[i]) slots[i] = (n == 0) ? {1'b0, 7'(i + 1)} : rnd_slot();
      if (n == 1) slots[0] = 8'h00;
      if (n == 2) begin
        slots[0] = 8'h05;
        slots[1] = 8'h82;
      end
      wr_reg(SLOT_FOUR_ADDR, slots[3]);
      wr_reg(SLOT_FIVE_ADDR, slots[4]);
      rd_chk(SLOT_FOUR_ADDR, slots[3]);
      rd_chk(SLOT_FIVE_ADDR, slots[4]);
      predict();
      got_q = {};
      // Strobe held two cycles: the second trigger lands while busy
      @(posedge clk);
      wr <= 1'b1;
      addr <= TRIGGER_ADDR;
      wdata <= 8'h01;
      repeat (2) @(posedge clk);
      wr <= 1'b0;
      for (int k = 0; k < 500 && busy !== 1'b0; k++) begin
        @(posedge clk);
        #1;
      end
      chk({7'h00, busy}, 8'h00);
      chk(8'(got_q.size()), 8'(exp_q.size()));
      foreach (exp_q[i]) if (i < got_q.size()) chk(got_q[i], exp_q[i]);
      if (n == 0) rd_chk(STATUS_ADDR, 8'(SLOT_COUNT - 1));
    end
    summarize();
  end
  // Watchdog against a hung sequencer
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule // tb_top
